/* File: rtl/tmc_pkg.sv */
// Package for the 8-bit timer with one compare channel.
// Assumes a single 10 MHz clock and an APB register slave.
package tmc_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] TMC_ADDR_CTRL   = 8'h00;
    localparam logic [7:0] TMC_ADDR_COUNT  = 8'h04;
    localparam logic [7:0] TMC_ADDR_CMP    = 8'h08;
    localparam logic [7:0] TMC_ADDR_FLAGS  = 8'h0C;
    localparam logic [7:0] TMC_ADDR_IRQEN  = 8'h10;
    localparam logic [7:0] TMC_ADDR_ASYNC  = 8'h14;

    // ****************************************
    // Control, flag and irq enable field positions
    // ****************************************
    localparam int TMC_CS_LSB   = 0;
    localparam int TMC_WGM_LSB  = 3;
    localparam int TMC_COM_LSB  = 5;
    localparam int TMC_FOC_BIT  = 7;
    localparam int TMC_OCF_BIT  = 1;
    localparam int TMC_TOV_BIT  = 0;

    // ****************************************
    // Reset values and limits
    // ****************************************
    localparam logic [7:0] TMC_CTRL_RST  = 8'h00;
    localparam logic [7:0] TMC_COUNT_RST = 8'h00;
    localparam logic [7:0] TMC_CMP_RST   = 8'h00;
    localparam logic [7:0] TMC_MAX       = 8'hFF;
    localparam logic [7:0] TMC_BOTTOM    = 8'h00;
    localparam logic [2:0] TMC_CS_STOP   = 3'h0;
    localparam int         TMC_PRESC_W   = 10;

    typedef enum logic [1:0] {
        TMC_WGM_NORMAL = 2'b00,
        TMC_WGM_PCPWM  = 2'b01,
        TMC_WGM_CTC    = 2'b10,
        TMC_WGM_FAST   = 2'b11
    } tmc_wgm_e;

endpackage

/* File: rtl/tmc_tick_sync.sv */
// Turns the oscillator pin into one-cycle tick enables on clk.
// Assumes the oscillator is far slower than clk; pin is asynchronous.
`timescale 1ns/1ns
`default_nettype none
module tmc_tick_sync
    import tmc_pkg::*;
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic osc_pin_in,
    output var  logic tick
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic tick;
    } tmc_sync_s;

    tmc_sync_s q;
    tmc_sync_s d;

    always_comb
    begin
        d      = q;
        d.s1   = osc_pin_in;
        d.s2   = q.s1;
        d.s3   = q.s2;
        // Rising edge seen only after the second stage
        d.tick = q.s2 & ~q.s3;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            q <= '0;
        else
            q <= d;
    end

    assign tick = q.tick;

endmodule
`default_nettype wire

/* File: rtl/tmc_timer.sv */
// 8-bit up/down timer, one compare channel, waveform pin override, APB slave.
// Assumes one 10 MHz clock; oscillator and port pins arrive asynchronously.
//
// Contract
// - Timer clock from I/O clock, or oscillator when async select set; clock selects 6 and 7 count ext_clk_pin edges instead.
// - Each timer tick clears, increments or decrements per mode.
// - Clock select zero stops the counter.
// - Counter readable and writable with or without timer ticks.
// - CPU counter write beats clear or count in same cycle.
// - Mode bits set sequence; overflow flag set where mode defines.
// - Continuous compare; flag set on tick after the match.
// - Flag and irq enable raise compare interrupt request.
// - Flag cleared by interrupt acknowledge or by writing one.
// - PWM modes double buffer compare, loaded at top or bottom.
// - Compare access hits buffer in PWM, active register otherwise.
// - Force strobe in non-PWM updates output only, no flag, no reload.
// - Counter write blocks compare match on next tick, even stopped.
// - Output state kept across mode changes.
// - Output mode unbuffered; acts at next match or force.
// - Output mode nonzero overrides port value; direction still rules.
// - Output mode zero leaves output state unchanged at match.
// - Output mode selects polarity in PWM, set/clear/toggle otherwise.
// - Output state settable while pin direction is input.
// - Mode codes: normal 0, phase PWM 1, CTC 2, fast PWM 3.
// - Max at 0xFF, bottom at 0x00.
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module tmc_timer
    import tmc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        osc_pin_in,
    input  wire logic        ext_clk_pin,
    input  wire logic        port_value,
    input  wire logic        waveform_pin_direction,
    input  wire logic        irq_ack,
    output var  logic        pin_out,
    output var  logic        pin_oe,
    output var  logic        compare_irq,
    output var  logic        overflow_irq
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [2:0]                 clock_select;
        tmc_wgm_e                   waveform_mode;
        logic [1:0]                 compare_output_mode;
        logic                       async_clock_select;
        logic                       compare_irq_enable;
        logic                       overflow_irq_enable;
        logic [7:0]                 count_value;
        logic [7:0]                 compare_value;
        logic [7:0]                 compare_buffer;
        logic                       compare_match_flag;
        logic                       overflow_flag;
        logic                       count_down;
        logic                       block_match;
        logic                       match_pending;
        logic                       wave_state;
        logic [TMC_PRESC_W-1:0]     presc;
        logic                       ext_s1;
        logic                       ext_s2;
        logic                       ext_s3;
        logic                       pdir_s1;
        logic                       pdir_s2;
        logic                       pval_s1;
        logic                       pval_s2;
        logic [31:0]                prdata;
        logic                       pready;
        logic                       pslverr;
        logic                       pin_out;
        logic                       pin_oe;
        logic                       compare_irq;
        logic                       overflow_irq;
    } tmc_state_s;

    tmc_state_s q;
    tmc_state_s d;
    logic       osc_tick;

    tmc_tick_sync u_sync (
        .clk        (clk),
        .arst_n     (arst_n),
        .osc_pin_in (osc_pin_in),
        .tick       (osc_tick)
    );

    logic                   pwm_mode;
    logic                   base_tick;
    logic                   tick;
    logic                   wr_en;
    logic                   rd_en;
    logic                   ovf_evt;
    logic                   at_top;
    logic                   match;
    logic [TMC_PRESC_W-1:0] presc_next;
    logic [7:0]             ctrl_rd;

    always_comb
    begin
        pwm_mode   = q.waveform_mode[0];
        wr_en      = psel & penable & pwrite;
        rd_en      = psel & ~penable & ~pwrite;
        presc_next = q.presc + {{(TMC_PRESC_W-1){1'b0}}, 1'b1};
        base_tick  = q.async_clock_select ? osc_tick : 1'b1;
        case (q.clock_select)
            3'd0:    tick = 1'b0;
            3'd1:    tick = base_tick;
            3'd2:    tick = base_tick && (q.presc[2:0] == 3'h7);
            3'd3:    tick = base_tick && (q.presc[5:0] == 6'h3F);
            3'd4:    tick = base_tick && (q.presc[7:0] == 8'hFF);
            3'd5:    tick = base_tick && (q.presc == {TMC_PRESC_W{1'b1}});
            3'd6:    tick = q.ext_s2 & ~q.ext_s3;
            default: tick = ~q.ext_s2 & q.ext_s3;
        endcase
        at_top = (q.waveform_mode == TMC_WGM_CTC) ? (q.count_value == q.compare_value)
                                                  : (q.count_value == TMC_MAX);
        match  = (q.count_value == q.compare_value) && !q.block_match;
        // overflow event, so a same-cycle clear loses
        ovf_evt = tick && ((q.waveform_mode == TMC_WGM_PCPWM) ? (q.count_value == TMC_BOTTOM && q.count_down)
                                                              : (q.count_value == TMC_MAX));
        ctrl_rd = {1'b0, q.compare_output_mode, q.waveform_mode, q.clock_select};
    end

    always_comb
    begin
        d = q;
        d.ext_s1  = ext_clk_pin;
        d.ext_s2  = q.ext_s1;
        d.ext_s3  = q.ext_s2;
        d.pdir_s1 = waveform_pin_direction;
        d.pdir_s2 = q.pdir_s1;
        d.pval_s1 = port_value;
        d.pval_s2 = q.pval_s1;
        if (base_tick)
            d.presc = presc_next;
        d.pready  = psel & ~penable;
        d.pslverr = 1'b0;

        // ****************************************
        // Counter and compare
        // ****************************************
        if (tick)
        begin
            // blocking lasts one timer tick only
            d.block_match = 1'b0;
            // flag follows on the next tick
            d.match_pending = match;
            if (q.match_pending)
                d.compare_match_flag = 1'b1;
            case (q.waveform_mode)
                TMC_WGM_PCPWM:
                begin
                    if (q.count_value == TMC_MAX)
                    begin
                        d.count_down  = 1'b1;
                        d.count_value = q.count_value - 8'h01;
                    end
                    else if (q.count_value == TMC_BOTTOM && q.count_down)
                    begin
                        d.count_down    = 1'b0;
                        d.count_value   = q.count_value + 8'h01;
                        d.overflow_flag = 1'b1;
                        // load at bottom in phase PWM
                        d.compare_value = q.compare_buffer;
                    end
                    else
                        d.count_value = q.count_down ? q.count_value - 8'h01 : q.count_value + 8'h01;
                    if (q.count_value == TMC_MAX)
                        d.compare_value = q.compare_buffer;
                end
                TMC_WGM_CTC:
                begin
                    d.count_down  = 1'b0;
                    d.count_value = (at_top && !q.block_match) ? TMC_BOTTOM : q.count_value + 8'h01;
                    if (q.count_value == TMC_MAX)
                        d.overflow_flag = 1'b1;
                end
                default:
                begin
                    d.count_down  = 1'b0;
                    d.count_value = q.count_value + 8'h01;
                    if (q.count_value == TMC_MAX)
                    begin
                        d.overflow_flag = 1'b1;
                        if (q.waveform_mode == TMC_WGM_FAST)
                            d.compare_value = q.compare_buffer;
                    end
                end
            endcase

            // ****************************************
            // Waveform state
            // ****************************************
            // mode zero never changes the state
            if (match && q.compare_output_mode != 2'b00)
            begin
                if (!pwm_mode)
                    case (q.compare_output_mode)
                        2'b01:   d.wave_state = ~q.wave_state;
                        2'b10:   d.wave_state = 1'b0;
                        default: d.wave_state = 1'b1;
                    endcase
                else if (q.compare_output_mode[1])
                    d.wave_state = (q.waveform_mode == TMC_WGM_PCPWM && q.count_down)
                                   ? ~q.compare_output_mode[0] : q.compare_output_mode[0];
            end
            if (q.waveform_mode == TMC_WGM_FAST && q.count_value == TMC_MAX
                && q.compare_output_mode[1] && !match)
                d.wave_state = ~q.compare_output_mode[0];
        end

        // ****************************************
        // Register writes
        // ****************************************
        if (wr_en)
        begin
            case (paddr)
                TMC_ADDR_CTRL:
                begin
                    d.clock_select        = pwdata[TMC_CS_LSB +: 3];
                    d.waveform_mode       = tmc_wgm_e'(pwdata[TMC_WGM_LSB +: 2]);
                    d.compare_output_mode = pwdata[TMC_COM_LSB +: 2];
                    if (pwdata[TMC_FOC_BIT] && !pwdata[TMC_WGM_LSB])
                        case (pwdata[TMC_COM_LSB +: 2])
                            2'b00:   d.wave_state = q.wave_state;
                            2'b01:   d.wave_state = ~q.wave_state;
                            2'b10:   d.wave_state = 1'b0;
                            default: d.wave_state = 1'b1;
                        endcase
                end
                TMC_ADDR_COUNT:
                begin
                    d.count_value   = pwdata[7:0];
                    d.block_match   = 1'b1;
                    d.match_pending = 1'b0;
                end
                TMC_ADDR_CMP:
                begin
                    d.compare_buffer = pwdata[7:0];
                    if (!pwm_mode)
                        d.compare_value = pwdata[7:0];
                end
                TMC_ADDR_IRQEN:
                begin
                    d.overflow_irq_enable = pwdata[TMC_TOV_BIT];
                    d.compare_irq_enable  = pwdata[TMC_OCF_BIT];
                end
                TMC_ADDR_ASYNC:
                    d.async_clock_select = pwdata[0];
                default:
                    d.pslverr = 1'b0;
            endcase
        end

        // clear by one-write or acknowledge; a same-cycle set wins
        if (((wr_en && paddr == TMC_ADDR_FLAGS && pwdata[TMC_OCF_BIT]) || irq_ack)
            && !(tick && q.match_pending))
            d.compare_match_flag = 1'b0;
        if (wr_en && paddr == TMC_ADDR_FLAGS && pwdata[TMC_TOV_BIT] && !ovf_evt)
            d.overflow_flag = 1'b0;

        // ****************************************
        // Read mux
        // ****************************************
        if (rd_en)
        begin
            case (paddr)
                TMC_ADDR_CTRL:  d.prdata = {24'h0, ctrl_rd};
                TMC_ADDR_COUNT: d.prdata = {24'h0, q.count_value};
                TMC_ADDR_CMP:   d.prdata = {24'h0, pwm_mode ? q.compare_buffer : q.compare_value};
                TMC_ADDR_FLAGS: d.prdata = {30'h0, q.compare_match_flag, q.overflow_flag};
                TMC_ADDR_IRQEN: d.prdata = {30'h0, q.compare_irq_enable, q.overflow_irq_enable};
                TMC_ADDR_ASYNC: d.prdata = {31'h0, q.async_clock_select};
                default:        d.prdata = 32'h0;
            endcase
            d.pslverr = !(paddr inside {TMC_ADDR_CTRL, TMC_ADDR_COUNT, TMC_ADDR_CMP,
                                        TMC_ADDR_FLAGS, TMC_ADDR_IRQEN, TMC_ADDR_ASYNC});
        end
        else if (psel && !penable)
        begin
            // Writes return zero data so a refused write shows no stale read
            d.prdata  = 32'h0;
            d.pslverr = !(paddr inside {TMC_ADDR_CTRL, TMC_ADDR_COUNT, TMC_ADDR_CMP,
                                        TMC_ADDR_FLAGS, TMC_ADDR_IRQEN, TMC_ADDR_ASYNC});
        end

        // ****************************************
        // Outputs
        // ****************************************
        // compare interrupt request
        d.compare_irq  = d.compare_match_flag & d.compare_irq_enable;
        d.overflow_irq = d.overflow_flag & d.overflow_irq_enable;
        // override when either mode bit set
        d.pin_out = (q.compare_output_mode != 2'b00) ? q.wave_state : q.pval_s2;
        d.pin_oe  = q.pdir_s2;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            q               <= '0;
            q.clock_select  <= TMC_CS_STOP;
            q.count_value   <= TMC_COUNT_RST;
            q.compare_value <= TMC_CMP_RST;
            q.compare_buffer <= TMC_CMP_RST;
            q.waveform_mode <= TMC_WGM_NORMAL;
        end
        else
            q <= d;
    end

    assign prdata       = q.prdata;
    assign pready       = q.pready;
    assign pslverr      = q.pslverr;
    assign pin_out      = q.pin_out;
    assign pin_oe       = q.pin_oe;
    assign compare_irq  = q.compare_irq;
    assign overflow_irq = q.overflow_irq;

endmodule
`default_nettype wire

/* File: verif/tmc_timer_props.sv */
// Concurrent checks on the timer's APB and pin ports.
// Assumes binding onto tmc_timer; single clock, async active-low reset.
`timescale 1ns/1ns
`default_nettype none
module tmc_timer_props
    import tmc_pkg::*;
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        waveform_pin_direction,
    input wire logic        irq_ack,
    input wire logic        pin_oe,
    input wire logic        compare_irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    logic mapped;
    assign mapped = (paddr <= TMC_ADDR_ASYNC) && (paddr[1:0] == 2'b00);

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_has_cause: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("ready without setup");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_error_unmapped: assert property (psel && !penable && !mapped |=> pslverr)
        else $error("unmapped access not refused");
    a_no_error_mapped: assert property (psel && !penable && mapped |=> !pslverr)
        else $error("mapped access refused");
    a_refused_reads_zero: assert property (pslverr |-> prdata == 32'h0)
        else $error("refused read carries data");
    a_upper_bits_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_ack_clears_irq: assert property (irq_ack |-> ##[1:3] !compare_irq)
        else $error("acknowledge left compare request up");
    a_oe_follows_dir: assert property ($stable(waveform_pin_direction) [*5] |-> pin_oe == waveform_pin_direction)
        else $error("pin enable ignores direction");
endmodule

bind tmc_timer tmc_timer_props u_props (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .waveform_pin_direction(waveform_pin_direction), .irq_ack(irq_ack), .pin_oe(pin_oe),
    .compare_irq(compare_irq));
`default_nettype wire

/* File: verif/tmc_far_side.sv */
// Far-side model: the processor's interrupt entry for the compare request.
// Assumes compare_irq is a level on clk; acknowledges after lat cycles.
`timescale 1ns/1ns
`default_nettype none
module tmc_far_side
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       enable,
    input  wire logic [3:0] lat,
    input  wire logic       compare_irq,
    output var  logic       irq_ack
);
    logic [3:0] wait_q;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wait_q  <= 4'h0;
            irq_ack <= 1'b0;
        end
        else
        begin
            irq_ack <= 1'b0;
            wait_q  <= 4'h0;
            // Re-ack suppressed while the last one is still in flight
            if (enable && compare_irq && !irq_ack)
            begin
                if (wait_q >= lat)
                    irq_ack <= 1'b1;
                else
                    wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verif/tmc_timer_bench.sv */
// Self-checking bench for the timer: APB master, pin and oscillator drive.
// Assumes the register map and pin latencies of tmc_pkg and the hand-over.
`timescale 1ns/1ns
`default_nettype none
module tmc_timer_bench
    import tmc_pkg::*;
;
    logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        osc_pin_in = 0, ext_clk_pin = 0, port_value = 0;
    logic        waveform_pin_direction = 0, ack_en = 0;
    logic [7:0]  paddr = 0, r;
    logic [31:0] pwdata = 0;
    logic [3:0]  lat = 0;
    logic [31:0] prdata;
    logic        pready, pslverr, irq_ack, pin_out, pin_oe, compare_irq, overflow_irq;
    logic [32:0] exp_q[$];
    int          bad_count = 0, n_compared = 0;
    logic [7:0]  regs[6] = '{TMC_ADDR_CTRL, TMC_ADDR_COUNT, TMC_ADDR_CMP, TMC_ADDR_FLAGS, TMC_ADDR_IRQEN,
                             TMC_ADDR_ASYNC};
    logic [7:0]  pin_ctl[6] = '{8'h80, 8'h40, 8'h50, 8'hD0, 8'hB0, 8'hB8};
    logic        pin_exp[6];

    tmc_timer DUT (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_pin_in(osc_pin_in), .ext_clk_pin(ext_clk_pin), .port_value(port_value),
        .waveform_pin_direction(waveform_pin_direction), .irq_ack(irq_ack), .pin_out(pin_out),
        .pin_oe(pin_oe), .compare_irq(compare_irq), .overflow_irq(overflow_irq));
    tmc_far_side u_far (.clk(clk), .arst_n(arst_n), .enable(ack_en), .lat(lat),
        .compare_irq(compare_irq), .irq_ack(irq_ack));

    always #50 clk = ~clk;
    // Unused count pin kept busy so a wrong source select would show
    always @(posedge clk) ext_clk_pin <= 1'($urandom);

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w)
            exp_q.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        chk(n == 1, "ready not in first access cycle");
        // Idle edge: no strobe driven twice in one time step
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 33'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0, {25'h0, e});
    endtask

    task automatic wait_val(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        while (s !== v && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        chk(s === v, "wait for level");
    endtask

    task automatic pin_chk(input logic oe, input logic v);
        repeat (6) @(posedge clk);
        chk(pin_oe === oe && (!oe || pin_out === v), "pin level");
    endtask

    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Oldest pending read is due whenever a read completes
    always @(posedge clk)
    begin
        if (psel && penable && pready && !pwrite)
            chk({pslverr, prdata} === exp_q.pop_front(), "read data");
    end

    initial
    begin
        #(100 * 20000);
        bad_count++;
        report_and_stop;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        void'($urandom(32'h1714C99B));
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        foreach (regs[i]) rd(regs[i], 8'h00);
        apb(1'b0, 8'h18, 32'h0, {1'b1, 32'h0});
        for (int i = 0; i < 16; i++)
        begin
            wr(TMC_ADDR_CTRL, {1'b0, i[3:0], 3'h0});
            rd(TMC_ADDR_CTRL, {1'b0, i[3:0], 3'h0});
        end
        // Match present at start must not flag on the first tick
        r = 8'h10 + 8'($urandom % 96);
        // Normal mode first, so the compare write reaches the active register
        wr(TMC_ADDR_CTRL, 8'h00);
        wr(TMC_ADDR_COUNT, r);
        rd(TMC_ADDR_COUNT, r);
        wr(TMC_ADDR_CMP, r);
        wr(TMC_ADDR_IRQEN, 8'h02);
        wr(TMC_ADDR_CTRL, 8'h01);
        repeat (60) @(posedge clk);
        rd(TMC_ADDR_FLAGS, 8'h00);
        wait_val(compare_irq, 1'b1, 400);
        rd(TMC_ADDR_FLAGS, 8'h03);
        wr(TMC_ADDR_FLAGS, 8'h02);
        rd(TMC_ADDR_FLAGS, 8'h01);
        wr(TMC_ADDR_IRQEN, 8'h03);
        wait_val(overflow_irq, 1'b1, 10);
        wr(TMC_ADDR_FLAGS, 8'h01);
        wr(TMC_ADDR_IRQEN, 8'h02);
        rd(TMC_ADDR_FLAGS, 8'h00);
        ack_en <= 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            lat <= (k == 0) ? 4'h0 : 4'h5;
            wait_val(compare_irq, 1'b1, 400);
            wait_val(compare_irq, 1'b0, 20);
        end
        ack_en <= 1'b0;
        wr(TMC_ADDR_CTRL, 8'h00);
        wr(TMC_ADDR_FLAGS, 8'h03);
        // Oscillator source: only its rising edges advance the count
        wr(TMC_ADDR_COUNT, 8'h00);
        wr(TMC_ADDR_ASYNC, 8'h01);
        wr(TMC_ADDR_CTRL, 8'h01);
        repeat (20) @(posedge clk);
        repeat (3)
        begin
            osc_pin_in <= 1'b1;
            repeat (8) @(posedge clk);
            osc_pin_in <= 1'b0;
            repeat (8) @(posedge clk);
        end
        wr(TMC_ADDR_CTRL, 8'h00);
        rd(TMC_ADDR_COUNT, 8'h03);
        wr(TMC_ADDR_ASYNC, 8'h00);
        // Output state set up before the pin is enabled
        port_value <= 1'($urandom);
        wr(TMC_ADDR_CTRL, 8'hE0);
        pin_chk(1'b0, 1'b0);
        waveform_pin_direction <= 1'b1;
        pin_chk(1'b1, 1'b1);
        pin_exp = '{port_value, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
        foreach (pin_ctl[i])
        begin
            wr(TMC_ADDR_CTRL, pin_ctl[i]);
            pin_chk(1'b1, pin_exp[i]);
        end
        rd(TMC_ADDR_FLAGS, 8'h00);
        rd(TMC_ADDR_COUNT, 8'h03);
        wr(TMC_ADDR_CMP, 8'h55);
        rd(TMC_ADDR_CMP, 8'h55);
        report_and_stop;
    end
endmodule
`default_nettype wire
